// file: verilog/stss_pkg.sv
// Package for the servo torque state selector: types, register map, constants
package stss_pkg;

    localparam int TQ_W = 16;
    localparam int POS_W = 32;
    localparam int DLY_W = 16;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;

    // Torque scale in relative units
    localparam logic signed [TQ_W-1:0] TQ_PEAK = 16'sd30000;
    localparam logic signed [TQ_W-1:0] TQ_CONT = 16'sd20000;

    // Register offsets
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_TQ_CLM = 4'h1;
    localparam logic [ADDR_W-1:0] REG_TQ_CLH = 4'h2;
    localparam logic [ADDR_W-1:0] REG_TQ_OLM = 4'h3;
    localparam logic [ADDR_W-1:0] REG_TQ_OLH = 4'h4;
    localparam logic [ADDR_W-1:0] REG_DELAY = 4'h5;
    localparam logic [ADDR_W-1:0] REG_ERRLIM = 4'h6;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h7;

    // Control register fields
    localparam int CTRL_OPEN_LOOP = 0;
    localparam int CTRL_DITHER = 1;

    // Status register fields
    localparam int ST_TRAJ_ACTIVE = 0;
    localparam int ST_STATE_LO = 1;
    localparam int ST_MOVE_ERR = 3;
    localparam int ST_HOLD_ERR = 4;
    localparam int ST_CMD_RUN = 5;

    // Error limit fields
    localparam int ERL_MOVE_LO = 0;
    localparam int ERL_HOLD_LO = 16;
    localparam int ERL_W = 16;

    // Reset values
    localparam logic [DLY_W-1:0] DELAY_RST = 16'h0010;
    localparam logic signed [TQ_W-1:0] TQ_CLM_RST = 16'sd20000;
    localparam logic signed [TQ_W-1:0] TQ_CLH_RST = 16'sd15000;
    localparam logic signed [TQ_W-1:0] TQ_OLM_RST = 16'sd20000;
    localparam logic signed [TQ_W-1:0] TQ_OLH_RST = 16'sd10000;
    localparam logic [ERL_W-1:0] ERL_RST = 16'h0100;

    typedef enum logic [1:0] {
        STSS_CL_MOVE,
        STSS_CL_HOLD,
        STSS_OL_MOVE,
        STSS_OL_HOLD
    } stss_state_e;

    typedef enum {
        STSS_IDLE,
        STSS_RUN,
        STSS_DELAY
    } stss_traj_e;

    // Trajectory sample from the generator
    typedef struct packed {
        logic valid;
        logic last;
        logic signed [POS_W-1:0] pos;
        logic signed [POS_W-1:0] vel;
        logic signed [POS_W-1:0] acc;
    } stss_traj_s;

    // Command to the motor driver
    typedef struct packed {
        logic valid;
        logic open_loop;
        logic signed [POS_W-1:0] step;
        logic signed [POS_W-1:0] target;
        logic signed [TQ_W-1:0] torque;
    } stss_drive_s;

endpackage : stss_pkg

// file: verilog/stss_top.sv
// Servo torque state selector: motion state, control state and torque clamp
//
// Decided for this implementation: the register offsets and strobed register access.
module stss_top (
    input wire logic clock,
    input wire logic resetn,
    input wire logic servo_tick,
    input wire stss_pkg::stss_traj_s traj_in,
    input wire logic signed [stss_pkg::POS_W-1:0] feedback_pos,
    input wire logic signed [stss_pkg::TQ_W-1:0] torque_cmd,
    input wire logic dither_ol_move,
    input wire logic [stss_pkg::ADDR_W-1:0] bus_addr,
    input wire logic [stss_pkg::DATA_W-1:0] bus_wdata,
    input wire logic bus_write,
    input wire logic bus_read,
    output logic [stss_pkg::DATA_W-1:0] bus_rdata,
    output stss_pkg::stss_drive_s drive_out,
    output logic traj_active,
    output stss_pkg::stss_state_e ctrl_state,
    output logic move_err,
    output logic hold_err
);
    import stss_pkg::*;

    logic [1:0] ctrl_reg;
    logic signed [TQ_W-1:0] tq_lim_reg [4];
    logic [DLY_W-1:0] delay_reg;
    logic [ERL_W-1:0] erl_move_reg;
    logic [ERL_W-1:0] erl_hold_reg;
    logic [DATA_W-1:0] rdata_reg;
    stss_traj_e traj_reg;
    stss_traj_e traj_next;
    logic [DLY_W-1:0] dcnt_reg;
    logic [DLY_W-1:0] dcnt_next;
    stss_state_e state_reg;
    stss_drive_s drive_reg;
    logic signed [POS_W-1:0] target_reg;
    logic signed [POS_W-1:0] prev_target_reg;
    logic move_err_reg;
    logic hold_err_reg;
    logic traj_active_reg;

    // Register decode
    wire wr_ctrl = bus_write && (bus_addr == REG_CTRL);
    wire wr_clm = bus_write && (bus_addr == REG_TQ_CLM);
    wire wr_clh = bus_write && (bus_addr == REG_TQ_CLH);
    wire wr_olm = bus_write && (bus_addr == REG_TQ_OLM);
    wire wr_olh = bus_write && (bus_addr == REG_TQ_OLH);
    wire wr_dly = bus_write && (bus_addr == REG_DELAY);
    wire wr_erl = bus_write && (bus_addr == REG_ERRLIM);
    wire wr_status = bus_write && (bus_addr == REG_STATUS);

    // Moving while generator runs or delay counts
    wire moving = (traj_reg != STSS_IDLE);
    wire open_loop = ctrl_reg[CTRL_OPEN_LOOP];
    wire dither_en = ctrl_reg[CTRL_DITHER];

    // Control state selection
    wire use_ol_hold = open_loop || dither_en;
    wire use_ol_move = open_loop || (dither_en && dither_ol_move);
    wire stss_state_e state_next = stss_state_e'(moving
        ? (use_ol_move ? STSS_OL_MOVE : STSS_CL_MOVE)
        : (use_ol_hold ? STSS_OL_HOLD : STSS_CL_HOLD));

    // Limit of the newly selected state
    wire logic signed [TQ_W-1:0] lim_sel = tq_lim_reg[state_next];
    wire logic signed [TQ_W-1:0] lim_neg = -lim_sel;
    wire logic signed [TQ_W-1:0] tq_clamp = (torque_cmd > lim_sel) ? lim_sel
        : (torque_cmd < lim_neg) ? lim_neg : torque_cmd;

    // Target and position error
    wire logic signed [POS_W-1:0] target_next = (traj_in.valid && traj_reg == STSS_RUN) ? traj_in.pos
        : target_reg;
    wire logic signed [POS_W-1:0] pos_err = feedback_pos - target_next;
    wire logic [POS_W-1:0] err_mag = pos_err[POS_W-1] ? POS_W'(-pos_err) : POS_W'(pos_err);
    wire move_over = err_mag > {{(POS_W-ERL_W){1'b0}}, erl_move_reg};
    wire hold_over = err_mag > {{(POS_W-ERL_W){1'b0}}, erl_hold_reg};

    // Open loop step is the trajectory increment
    wire logic signed [POS_W-1:0] ol_step = target_next - prev_target_reg;

    // Trajectory generator activity
    always_comb begin
        traj_next = traj_reg;
        dcnt_next = dcnt_reg;
        case (traj_reg)
            STSS_IDLE: begin
                if (servo_tick && traj_in.valid) begin
                    traj_next = STSS_RUN;
                end
            end
            STSS_RUN: begin
                if (servo_tick && traj_in.valid && traj_in.last) begin
                    traj_next = STSS_DELAY;
                    dcnt_next = delay_reg;
                end
            end
            STSS_DELAY: begin
                if (servo_tick && traj_in.valid) begin
                    traj_next = STSS_RUN;
                end else if (servo_tick) begin
                    if (dcnt_reg == '0) begin
                        traj_next = STSS_IDLE;
                    end else begin
                        dcnt_next = dcnt_reg - 1'b1;
                    end
                end
            end
            default: begin
                traj_next = STSS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            traj_reg <= STSS_IDLE;
            dcnt_reg <= '0;
        end else begin
            traj_reg <= traj_next;
            dcnt_reg <= dcnt_next;
        end
    end

    // Configuration registers
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ctrl_reg <= '0;
            tq_lim_reg[STSS_CL_MOVE] <= TQ_CLM_RST;
            tq_lim_reg[STSS_CL_HOLD] <= TQ_CLH_RST;
            tq_lim_reg[STSS_OL_MOVE] <= TQ_OLM_RST;
            tq_lim_reg[STSS_OL_HOLD] <= TQ_OLH_RST;
            delay_reg <= DELAY_RST;
            erl_move_reg <= ERL_RST;
            erl_hold_reg <= ERL_RST;
        end else begin
            if (wr_ctrl) ctrl_reg <= bus_wdata[1:0];
            if (wr_clm) tq_lim_reg[STSS_CL_MOVE] <= sat_lim(bus_wdata);
            if (wr_clh) tq_lim_reg[STSS_CL_HOLD] <= sat_lim(bus_wdata);
            if (wr_olm) tq_lim_reg[STSS_OL_MOVE] <= sat_lim(bus_wdata);
            if (wr_olh) tq_lim_reg[STSS_OL_HOLD] <= sat_lim(bus_wdata);
            if (wr_dly) delay_reg <= bus_wdata[DLY_W-1:0];
            if (wr_erl) begin
                erl_move_reg <= bus_wdata[ERL_MOVE_LO +: ERL_W];
                erl_hold_reg <= bus_wdata[ERL_HOLD_LO +: ERL_W];
            end
        end
    end

    // Limits kept between zero and peak torque
    function automatic logic signed [TQ_W-1:0] sat_lim(input logic [DATA_W-1:0] v);
        logic signed [DATA_W-1:0] s;
        s = $signed(v);
        if (s < 0) begin
            sat_lim = '0;
        end else if (s > TQ_PEAK) begin
            sat_lim = TQ_PEAK;
        end else begin
            sat_lim = s[TQ_W-1:0];
        end
    endfunction : sat_lim

    // Servo cycle outputs
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_reg <= STSS_CL_HOLD;
            drive_reg <= '0;
            target_reg <= '0;
            prev_target_reg <= '0;
        end else begin
            drive_reg.valid <= servo_tick;
            if (servo_tick) begin
                state_reg <= state_next;
                target_reg <= target_next;
                prev_target_reg <= target_next;
                drive_reg.target <= target_next;
                case (state_next)
                    STSS_CL_MOVE: begin
                        drive_reg.open_loop <= 1'b0;
                        drive_reg.step <= ol_step;
                        drive_reg.torque <= tq_clamp;
                    end
                    STSS_CL_HOLD: begin
                        drive_reg.open_loop <= 1'b0;
                        drive_reg.step <= '0;
                        drive_reg.torque <= tq_clamp;
                    end
                    STSS_OL_MOVE: begin
                        drive_reg.open_loop <= 1'b1;
                        drive_reg.step <= ol_step;
                        drive_reg.torque <= lim_sel;
                    end
                    STSS_OL_HOLD: begin
                        drive_reg.open_loop <= 1'b1;
                        drive_reg.step <= '0;
                        drive_reg.torque <= lim_sel;
                    end
                    default: begin
                        drive_reg.open_loop <= 1'b0;
                        drive_reg.step <= '0;
                        drive_reg.torque <= '0;
                    end
                endcase
            end
        end
    end

    // Error flags, set wins over write-one clear
    wire move_set = servo_tick && moving && !use_ol_move && move_over;
    wire hold_set = servo_tick && !moving && !use_ol_hold && hold_over;
    wire move_clr = wr_status && bus_wdata[ST_MOVE_ERR];
    wire hold_clr = wr_status && bus_wdata[ST_HOLD_ERR];

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            move_err_reg <= 1'b0;
            hold_err_reg <= 1'b0;
        end else begin
            move_err_reg <= move_set || (move_err_reg && !move_clr);
            hold_err_reg <= hold_set || (hold_err_reg && !hold_clr);
        end
    end

    // Read mux
    wire logic [DATA_W-1:0] status_word = {{(DATA_W-6){1'b0}}, (traj_reg == STSS_RUN), hold_err_reg,
        move_err_reg, state_reg, moving};
    wire logic [DATA_W-1:0] rd_mux =
        (bus_addr == REG_CTRL) ? {{(DATA_W-2){1'b0}}, ctrl_reg} :
        (bus_addr == REG_TQ_CLM) ? DATA_W'($unsigned(tq_lim_reg[STSS_CL_MOVE])) :
        (bus_addr == REG_TQ_CLH) ? DATA_W'($unsigned(tq_lim_reg[STSS_CL_HOLD])) :
        (bus_addr == REG_TQ_OLM) ? DATA_W'($unsigned(tq_lim_reg[STSS_OL_MOVE])) :
        (bus_addr == REG_TQ_OLH) ? DATA_W'($unsigned(tq_lim_reg[STSS_OL_HOLD])) :
        (bus_addr == REG_DELAY) ? {{(DATA_W-DLY_W){1'b0}}, delay_reg} :
        (bus_addr == REG_ERRLIM) ? {erl_hold_reg, erl_move_reg} :
        (bus_addr == REG_STATUS) ? status_word : '0;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= bus_read ? rd_mux : '0;
        end
    end

    assign bus_rdata = rdata_reg;
    assign drive_out = drive_reg;
    assign traj_active = traj_active_reg;
    assign ctrl_state = state_reg;
    assign move_err = move_err_reg;
    assign hold_err = hold_err_reg;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            traj_active_reg <= 1'b0;
        end else begin
            traj_active_reg <= (traj_next != STSS_IDLE);
        end
    end

    // Assertions
    property p_state_moving;
        @(posedge clock) disable iff (!resetn)
        $rose(drive_reg.valid) |-> ((state_reg == STSS_CL_MOVE || state_reg == STSS_OL_MOVE) == $past(moving));
    endproperty
    a_state_moving: assert property (p_state_moving) else $error("state disagrees with motion");

    property p_clamp;
        @(posedge clock) disable iff (!resetn)
        drive_reg.valid && !drive_reg.open_loop |-> (drive_reg.torque <= tq_lim_reg[state_reg]
            && drive_reg.torque >= -tq_lim_reg[state_reg]);
    endproperty
    a_clamp: assert property (p_clamp) else $error("torque exceeds limit");

    property p_ol_torque;
        @(posedge clock) disable iff (!resetn)
        servo_tick && $stable(tq_lim_reg[STSS_OL_MOVE]) && state_next == STSS_OL_MOVE
            |=> drive_reg.torque == $past(tq_lim_reg[STSS_OL_MOVE]);
    endproperty
    a_ol_torque: assert property (p_ol_torque) else $error("open moving torque wrong");

    property p_ol_hold_still;
        @(posedge clock) disable iff (!resetn)
        servo_tick && state_next == STSS_OL_HOLD |=> drive_reg.step == '0 && drive_reg.open_loop;
    endproperty
    a_ol_hold_still: assert property (p_ol_hold_still) else $error("open hold moved");

    property p_cl_hold_still;
        @(posedge clock) disable iff (!resetn)
        servo_tick && state_next == STSS_CL_HOLD |=> drive_reg.step == '0 && !drive_reg.open_loop;
    endproperty
    a_cl_hold_still: assert property (p_cl_hold_still) else $error("closed hold stepped");

    sequence s_last_cmd;
        servo_tick && traj_reg == STSS_RUN && traj_in.valid && traj_in.last;
    endsequence
    property p_delay_start;
        @(posedge clock) disable iff (!resetn)
        s_last_cmd |=> traj_reg == STSS_DELAY && dcnt_reg == $past(delay_reg);
    endproperty
    a_delay_start: assert property (p_delay_start) else $error("delay not started");

    property p_dither_hold;
        @(posedge clock) disable iff (!resetn)
        !moving && dither_en |-> state_next == STSS_OL_HOLD;
    endproperty
    a_dither_hold: assert property (p_dither_hold) else $error("dither hold not open");

    property p_status_bit;
        @(posedge clock) disable iff (!resetn)
        bus_read && bus_addr == REG_STATUS |=> bus_rdata[ST_TRAJ_ACTIVE] == $past(moving);
    endproperty
    a_status_bit: assert property (p_status_bit) else $error("status bit wrong");

    property p_move_err;
        @(posedge clock) disable iff (!resetn)
        move_set |=> move_err_reg;
    endproperty
    a_move_err: assert property (p_move_err) else $error("moving error lost");

    property p_step;
        @(posedge clock) disable iff (!resetn)
        servo_tick && state_next == STSS_OL_MOVE |=> drive_reg.step == drive_reg.target - $past(prev_target_reg);
    endproperty
    a_step: assert property (p_step) else $error("step not increment");

endmodule : stss_top

// file: testbench/stss_partner.sv
// Motor driver and position feedback model for the torque state selector bench
module stss_partner (
    input wire logic clock,
    input wire logic resetn,
    input wire stss_pkg::stss_drive_s drive,
    input wire logic signed [stss_pkg::POS_W-1:0] jam_offs,
    output logic signed [stss_pkg::POS_W-1:0] feedback_pos
);
    import stss_pkg::*;
    logic signed [POS_W-1:0] shaft_reg;
    logic signed [POS_W-1:0] shaft_next;
    // Open loop finishes each step move whatever the load; closed loop follows target plus jam offset
    assign shaft_next = drive.open_loop ? shaft_reg + drive.step : drive.target + jam_offs;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            shaft_reg <= '0;
        end else if (drive.valid) begin
            shaft_reg <= shaft_next;
        end
    end
    assign feedback_pos = shaft_reg;
endmodule : stss_partner

// file: testbench/test_stss_top.sv
// Testbench for the servo torque state selector
module test_stss_top;
    timeunit 1ns;
    timeprecision 100ps;
    import stss_pkg::*;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic servo_tick = 1'b0;
    stss_traj_s traj_in = '0;
    logic signed [POS_W-1:0] feedback_pos;
    logic signed [POS_W-1:0] jam_offs = '0;
    logic signed [TQ_W-1:0] torque_cmd = '0;
    logic dither_ol_move = 1'b0;
    logic [ADDR_W-1:0] bus_addr = '0;
    logic [DATA_W-1:0] bus_wdata = '0;
    logic bus_write = 1'b0;
    logic bus_read = 1'b0;
    logic [DATA_W-1:0] bus_rdata;
    stss_drive_s drive_out;
    logic traj_active;
    stss_state_e ctrl_state;
    logic move_err;
    logic hold_err;
    logic [DATA_W-1:0] rv;
    int n_fail = 0;
    int n_tests = 0;

    always #5 clock = ~clock;

    stss_top dut (.clock(clock), .resetn(resetn), .servo_tick(servo_tick), .traj_in(traj_in),
        .feedback_pos(feedback_pos), .torque_cmd(torque_cmd), .dither_ol_move(dither_ol_move),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_write(bus_write), .bus_read(bus_read),
        .bus_rdata(bus_rdata), .drive_out(drive_out), .traj_active(traj_active), .ctrl_state(ctrl_state),
        .move_err(move_err), .hold_err(hold_err));

    stss_partner motor (.clock(clock), .resetn(resetn), .drive(drive_out), .jam_offs(jam_offs),
        .feedback_pos(feedback_pos));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clock);
        bus_addr <= a;
        bus_wdata <= d;
        bus_write <= 1'b1;
        @(posedge clock);
        bus_write <= 1'b0;
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clock);
        bus_addr <= a;
        bus_read <= 1'b1;
        @(posedge clock);
        bus_read <= 1'b0;
        #1;
        d = bus_rdata;
    endtask : rd

    // One servo cycle; the drive command must pulse in the cycle after the tick
    task automatic tick(input logic v, input logic l, input logic signed [POS_W-1:0] p);
        @(posedge clock);
        servo_tick <= 1'b1;
        traj_in <= {v, l, p, 32'sd0, 32'sd0};
        @(posedge clock);
        servo_tick <= 1'b0;
        #1;
        chk(drive_out.valid, 1'b1);
    endtask : tick

    task automatic idle(input int n);
        repeat (n) tick(1'b0, 1'b0, '0);
    endtask : idle

    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (50000) @(posedge clock);
        n_fail++;
        test_done();
    end

    initial begin
        repeat (12) @(posedge clock);
        chk(ctrl_state, STSS_CL_HOLD);
        resetn <= 1'b1;
        // Reset values, saturation and unmapped address
        rd(REG_TQ_CLM, rv);
        chk(rv[TQ_W-1:0], TQ_CLM_RST);
        rd(REG_TQ_CLH, rv);
        chk(rv[TQ_W-1:0], TQ_CLH_RST);
        rd(REG_TQ_OLM, rv);
        chk(rv[TQ_W-1:0], TQ_OLM_RST);
        rd(REG_TQ_OLH, rv);
        chk(rv[TQ_W-1:0], TQ_OLH_RST);
        rd(REG_DELAY, rv);
        chk(rv[DLY_W-1:0], DELAY_RST);
        rd(REG_ERRLIM, rv);
        chk(rv, {ERL_RST, ERL_RST});
        rd(4'hC, rv);
        chk(rv, 32'h00000000);
        wr(REG_TQ_CLM, 32'd40000);
        rd(REG_TQ_CLM, rv);
        chk(rv[TQ_W-1:0], TQ_PEAK);
        $display("Test registers done");
        // Closed loop moving with symmetric clamp at continuous torque
        wr(REG_TQ_CLM, 32'(TQ_CONT));
        wr(REG_DELAY, 32'd3);
        torque_cmd <= TQ_PEAK;
        tick(1'b1, 1'b0, 32'sd0);
        chk(ctrl_state, STSS_CL_HOLD);
        tick(1'b1, 1'b0, 32'sd0);
        chk(ctrl_state, STSS_CL_MOVE);
        chk(drive_out.torque, TQ_CONT);
        torque_cmd <= -TQ_PEAK;
        tick(1'b1, 1'b0, 32'sd50);
        chk(drive_out.torque, -TQ_CONT);
        chk(drive_out.target, 32'sd50);
        rd(REG_STATUS, rv);
        chk(rv[2:0], 3'h1);
        // Delay to holding: last sample then exactly delay+1 ticks
        tick(1'b1, 1'b1, 32'sd100);
        idle(3);
        chk(traj_active, 1'b1);
        chk(drive_out.torque, -TQ_CONT);
        idle(1);
        chk(traj_active, 1'b0);
        idle(1);
        chk(ctrl_state, STSS_CL_HOLD);
        chk(drive_out.torque, -TQ_CLH_RST);
        chk(drive_out.step, 32'sd0);
        rd(REG_STATUS, rv);
        chk(rv[2:0], 3'h2);
        $display("Test closed loop done");
        // Jammed shaft while moving raises the moving error, then it is cleared
        jam_offs <= 32'sd1000;
        tick(1'b1, 1'b0, 32'sd200);
        tick(1'b1, 1'b0, 32'sd300);
        tick(1'b1, 1'b0, 32'sd300);
        chk(move_err, 1'b1);
        chk(hold_err, 1'b0);
        wr(REG_STATUS, 32'h00000008);
        rd(REG_STATUS, rv);
        chk(rv[ST_MOVE_ERR], 1'b0);
        chk(move_err, 1'b0);
        jam_offs <= 32'sd0;
        $display("Test moving error done");
        // Open loop moving then holding
        wr(REG_CTRL, 32'h00000001);
        tick(1'b1, 1'b0, 32'sd400);
        tick(1'b1, 1'b0, 32'sd500);
        chk(ctrl_state, STSS_OL_MOVE);
        chk(drive_out.open_loop, 1'b1);
        chk(drive_out.step, 32'sd100);
        chk(drive_out.torque, TQ_OLM_RST);
        tick(1'b1, 1'b1, 32'sd500);
        idle(5);
        chk(ctrl_state, STSS_OL_HOLD);
        chk(drive_out.step, 32'sd0);
        chk(drive_out.torque, TQ_OLH_RST);
        $display("Test open loop done");
        // Dither suppression: open loop moving on request, open loop holding, off gives closed loop holding
        wr(REG_CTRL, 32'h00000002);
        dither_ol_move <= 1'b1;
        tick(1'b1, 1'b0, 32'sd500);
        chk(ctrl_state, STSS_OL_HOLD);
        tick(1'b1, 1'b1, 32'sd500);
        chk(ctrl_state, STSS_OL_MOVE);
        chk(drive_out.torque, TQ_OLM_RST);
        idle(5);
        chk(ctrl_state, STSS_OL_HOLD);
        dither_ol_move <= 1'b0;
        wr(REG_CTRL, 32'h00000000);
        idle(1);
        chk(ctrl_state, STSS_CL_HOLD);
        chk(hold_err, 1'b1);
        $display("Test dither done");
        test_done();
    end
endmodule : test_stss_top
